// ==== rtl/fpm_top.sv ====
// Group fault propagation and turn-off sequencing of one load converter module.
// Assumes fault detectors and the power stage run on i_clk; the group line and the
// manager's error flag arrive from pins and are synchronised here.
module fpm_top
    import fpm_pkg::*;
#(
    parameter int unsigned HICCUP_CYC = FPM_HICCUP_CYC
) (
    input wire logic i_clk,                       // 20 MHz clock
    input wire logic i_arst_n,                    // Async reset, active low
    input wire logic i_cfg_wr,                    // Write strobe for propagation_config
    input wire logic [FPM_CFG_W-1:0] i_cfg_wdata, // Write data
    output logic [FPM_CFG_W-1:0] o_cfg_rdata,     // propagation_config contents
    input wire logic i_turn_on,                   // Turn-on command level
    input wire fpm_prot_t i_fault,                // Detected faults and errors, levels
    input wire fpm_prot_t i_latching,             // 1 = latching type per protection
    input wire logic i_temp_warn,                 // Overtemperature warning level
    input wire logic i_pg_warn,                   // Power good warning level
    input wire logic i_status_clear,              // Pulse: clear fault status
    input wire logic [FPM_CNT_W-1:0] i_toff_delay, // Programmed turn-off delay, cycles
    input wire logic i_vout_zero,                 // Output has ramped to zero
    input wire logic i_grp_line,                  // Group fault line level (pin)
    input wire logic i_remote_err,                // Manager flags an error propagation (pin)
    output logic o_grp_out,                       // Group line output value, always low
    output logic o_grp_oe,                        // Group line enable, high pulls low
    output fpm_drive_t o_drive,                   // Power stage commands
    output logic o_msg_temp,                      // Temperature warning message
    output logic o_msg_pg,                        // Power good warning message
    output fpm_prot_t o_fault_status,             // Sticky fault status
    output fpm_state_t o_state                    // Sequencer state
);

    // -------------------------------------------------------------
    // Configuration register
    // -------------------------------------------------------------
    logic [FPM_CFG_W-1:0] cfg;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg <= FPM_CFG_RST;
        end else if (i_cfg_wr) begin
            cfg <= i_cfg_wdata;
        end
    end

    assign o_cfg_rdata = cfg;

    // -------------------------------------------------------------
    // Pin inputs
    // -------------------------------------------------------------
    logic grp_level;
    logic remote_err;

    fpm_sync2 #(.RST_VAL(1'b1)) u_sync_grp (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_d(i_grp_line),
        .o_q(grp_level)
    );

    fpm_sync2 #(.RST_VAL(1'b0)) u_sync_err (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_d(i_remote_err),
        .o_q(remote_err)
    );

    // -------------------------------------------------------------
    // Decoding
    // -------------------------------------------------------------
    fpm_state_t state;
    fpm_state_t next_state;
    logic pull;
    logic next_pull;
    logic err;
    logic next_err;
    logic latched;
    logic next_latched;
    logic stop_only;
    logic next_stop_only;
    logic [2:0] pull_hist;
    logic tmr_load;
    logic [FPM_CNT_W-1:0] tmr_val;
    logic tmr_done;
    fpm_drive_t next_drive;

    wire fpm_prot_t prop_mask = '{
        ov: cfg[FPM_B_OV],
        tr: cfg[FPM_B_TRK],
        ot: cfg[FPM_B_OT],
        oc: cfg[FPM_B_OC],
        uv: cfg[FPM_B_UV]
    };
    // Phase voltage bit is stored only: no detector feeds it
    wire fault_any = |i_fault;
    wire own_prop = |(i_fault & prop_mask);
    wire fast_cause = i_fault.oc | i_fault.tr | i_fault.ov;
    wire latch_cause = |(i_fault & i_latching);
    // Our own release takes three cycles to clear the synchroniser, so a low
    // line is only blamed on others once our pull has been off that long
    wire own_recent = pull | (|pull_hist);
    wire remote_low = ~grp_level & ~own_recent;
    wire [FPM_CNT_W-1:0] hiccup_val = FPM_CNT_W'(HICCUP_CYC);

    // -------------------------------------------------------------
    // Timer shared by turn-off delay and hiccup
    // -------------------------------------------------------------
    fpm_timer u_timer (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_load(tmr_load),
        .i_value(tmr_val),
        .o_done(tmr_done)
    );

    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pull = pull;
        next_err = err;
        next_latched = latched;
        next_stop_only = stop_only;
        tmr_load = 1'b0;
        tmr_val = i_toff_delay;
        case (state)
            FPM_ST_OFF: begin
                next_pull = 1'b0;
                next_err = 1'b0;
                if (i_turn_on && !fault_any && !remote_low) begin
                    next_state = FPM_ST_RUN;
                end
            end
            FPM_ST_RUN: begin
                if (fault_any) begin
                    tmr_load = 1'b1;
                    next_pull = own_prop;
                    next_err = i_fault.ov;
                    next_latched = latch_cause;
                    next_stop_only = 1'b0;
                    next_state = fast_cause ? FPM_ST_FAST : FPM_ST_DELAY;
                end else if (remote_low) begin
                    tmr_load = 1'b1;
                    next_latched = 1'b0;
                    next_stop_only = 1'b0;
                    // Error relayed by the manager: both switches off at once
                    next_state = remote_err ? FPM_ST_FAST : FPM_ST_DELAY;
                end else if (!i_turn_on) begin
                    tmr_load = 1'b1;
                    next_latched = 1'b0;
                    next_stop_only = 1'b1;
                    next_state = FPM_ST_DELAY;
                end
            end
            FPM_ST_DELAY: begin
                if (tmr_done) begin
                    next_state = FPM_ST_RAMP_DN;
                end
            end
            FPM_ST_RAMP_DN, FPM_ST_FAST: begin
                if (i_vout_zero) begin
                    if (stop_only) begin
                        next_state = FPM_ST_OFF;
                    end else begin
                        // Interval starts at zero output, not at the fault
                        tmr_load = 1'b1;
                        tmr_val = hiccup_val;
                        next_state = FPM_ST_HICCUP;
                    end
                end
            end
            FPM_ST_HICCUP: begin
                if (tmr_done) begin
                    if (latched) begin
                        next_state = FPM_ST_LATCHED;
                    end else if (!i_turn_on) begin
                        next_state = FPM_ST_OFF;
                    end else if (fault_any || remote_low) begin
                        tmr_load = 1'b1;
                        tmr_val = hiccup_val;
                    end else begin
                        next_pull = 1'b0;
                        next_err = 1'b0;
                        next_state = FPM_ST_RUN;
                    end
                end
            end
            FPM_ST_LATCHED: begin
                // Command cycling or a clear with the cause gone releases it
                if (!i_turn_on || (i_status_clear && !fault_any)) begin
                    next_state = FPM_ST_OFF;
                end
            end
            default: begin
                next_state = FPM_ST_OFF;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Power stage commands
    // -------------------------------------------------------------
    always_comb begin
        next_drive = '0;
        next_drive.ramp_up = (next_state == FPM_ST_RUN);
        next_drive.regular_off = (next_state == FPM_ST_RAMP_DN);
        next_drive.fast_off = (next_state == FPM_ST_FAST);
        // Low side stays on after an own error until the next start attempt or the return to off
        next_drive.low_side_on = next_err && (next_state == FPM_ST_FAST ||
            next_state == FPM_ST_HICCUP || next_state == FPM_ST_LATCHED);
    end

    // -------------------------------------------------------------
    // State registers
    // -------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= FPM_ST_OFF;
            pull <= 1'b0;
            err <= 1'b0;
            latched <= 1'b0;
            stop_only <= 1'b0;
            pull_hist <= '0;
            o_drive <= '0;
        end else begin
            state <= next_state;
            pull <= next_pull;
            err <= next_err;
            latched <= next_latched;
            stop_only <= next_stop_only;
            pull_hist <= {pull_hist[1:0], pull};
            o_drive <= next_drive;
        end
    end

    // Open drain: value is always low, only the enable moves
    assign o_grp_out = 1'b0;
    assign o_grp_oe = pull;
    assign o_state = state;

    // -------------------------------------------------------------
    // Status and warning messages
    // -------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_fault_status <= '0;
            o_msg_temp <= 1'b0;
            o_msg_pg <= 1'b0;
        end else begin
            // A fault present in the clear cycle stays recorded
            o_fault_status <= (i_status_clear ? fpm_prot_t'('0) : o_fault_status) | i_fault;
            o_msg_temp <= i_temp_warn & cfg[FPM_B_TEMP_MSG];
            o_msg_pg <= i_pg_warn & cfg[FPM_B_PG_MSG];
        end
    end

endmodule : fpm_top

// ==== shared/fpm_pkg.sv ====
// Constants, field layouts and carrier types for the group fault propagation logic.
// Assumes one 20 MHz clock and fault detectors running on that same clock.
package fpm_pkg;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int unsigned FPM_CLK_HZ = 20_000_000;
    localparam int unsigned FPM_HICCUP_MS = 130;
    localparam int unsigned FPM_HICCUP_CYC = FPM_CLK_HZ / 1000 * FPM_HICCUP_MS;
    localparam int FPM_CNT_W = 22;

    // -------------------------------------------------------------
    // Propagation configuration register fields
    // -------------------------------------------------------------
    localparam int FPM_CFG_W = 8;
    localparam int FPM_B_TEMP_MSG = 7;
    localparam int FPM_B_PG_MSG = 6;
    localparam int FPM_B_TRK = 5;
    localparam int FPM_B_OT = 4;
    localparam int FPM_B_OC = 3;
    localparam int FPM_B_UV = 2;
    localparam int FPM_B_OV = 1;
    localparam int FPM_B_PV = 0;
    localparam logic [FPM_CFG_W-1:0] FPM_CFG_RST = 8'h3e;

    // -------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------
    // One bit per protection that shuts the output down
    typedef struct packed {
        logic ov;
        logic tr;
        logic ot;
        logic oc;
        logic uv;
    } fpm_prot_t;

    // Commands to the power stage
    typedef struct packed {
        logic ramp_up;
        logic regular_off;
        logic fast_off;
        logic low_side_on;
    } fpm_drive_t;

    typedef enum logic [2:0] {
        FPM_ST_OFF,
        FPM_ST_RUN,
        FPM_ST_DELAY,
        FPM_ST_RAMP_DN,
        FPM_ST_FAST,
        FPM_ST_HICCUP,
        FPM_ST_LATCHED
    } fpm_state_t;

endpackage : fpm_pkg

// ==== rtl/fpm_sync2.sv ====
// Two flip-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to i_clk.
module fpm_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic i_clk,    // System clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_d,      // Pin level
    output logic o_q           // Synchronised level
);
    logic meta;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end

endmodule : fpm_sync2

// ==== rtl/fpm_timer.sv ====
// Loadable down counter for turn-off delay and hiccup interval.
// Assumes only one of the two intervals is running at a time.
module fpm_timer
    import fpm_pkg::*;
(
    input wire logic i_clk,                    // System clock
    input wire logic i_arst_n,                 // Async reset, active low
    input wire logic i_load,                   // Start a new interval
    input wire logic [FPM_CNT_W-1:0] i_value,  // Interval length in cycles
    output logic o_done                        // Count has reached zero
);
    logic [FPM_CNT_W-1:0] cnt;

    assign o_done = (cnt == '0);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt <= '0;
        end else if (i_load) begin
            cnt <= i_value;
        end else if (!o_done) begin
            cnt <= cnt - 1'b1;
        end
    end

endmodule : fpm_timer

// ==== tb/fpm_sva.sv ====
// Checker on the ports of fpm_top, attached by bind.
// Assumes one clock domain and the pins driven from it.
module fpm_sva
    import fpm_pkg::*;
#(
    parameter int unsigned HICCUP_CYC = 20
) (
    input wire logic i_clk,                       // Clock
    input wire logic i_arst_n,                    // Reset, active low
    input wire logic i_cfg_wr,                    // Write strobe
    input wire logic [FPM_CFG_W-1:0] i_cfg_wdata, // Write data
    input wire logic [FPM_CFG_W-1:0] o_cfg_rdata, // Config contents
    input wire logic i_turn_on,                   // Turn-on command
    input wire fpm_prot_t i_fault,                // Detector levels
    input wire logic i_temp_warn,                 // Temperature warning
    input wire logic i_pg_warn,                   // Power good warning
    input wire logic i_status_clear,              // Status clear pulse
    input wire logic i_grp_line,                  // Group line pin
    input wire logic i_remote_err,                // Error flag pin
    input wire logic o_grp_out,                   // Line output value
    input wire logic o_grp_oe,                    // Line pull enable
    input wire fpm_drive_t o_drive,               // Stage commands
    input wire logic o_msg_temp,                  // Temperature message
    input wire logic o_msg_pg,                    // Power good message
    input wire fpm_state_t o_state                // Sequencer state
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic [31:0] hic_cnt;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) hic_cnt <= '0;
        else hic_cnt <= (o_state == FPM_ST_HICCUP) ? hic_cnt + 32'h1 : '0;
    end
    // -------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------
    // Pin synchroniser adds delay, so the line must stay low a while
    sequence s_line_low;
        (!i_grp_line && !i_remote_err && i_fault == '0 && i_turn_on)[*3];
    endsequence
    sequence s_err_low;
        (!i_grp_line && i_remote_err && i_fault == '0 && i_turn_on)[*3];
    endsequence
    a_cfg_write_lands: assert property (i_cfg_wr |=> o_cfg_rdata == $past(i_cfg_wdata))
        else $error("config write lost");
    a_temp_msg_gate: assert property (!i_cfg_wr |=> o_msg_temp == $past(i_temp_warn && o_cfg_rdata[7]))
        else $error("temperature message wrong");
    a_pg_msg_gate: assert property (!i_cfg_wr |=> o_msg_pg == $past(i_pg_warn && o_cfg_rdata[6]))
        else $error("power good message wrong");
    a_line_value_low: assert property (o_grp_out == 1'b0)
        else $error("group line driven high");
    a_slow_fault_pull: assert property (o_state == FPM_ST_RUN && i_fault == 5'h01 && o_cfg_rdata[2] && !i_cfg_wr
        |=> o_state == FPM_ST_DELAY && o_grp_oe && !o_drive.ramp_up)
        else $error("undervoltage not handled");
    a_fast_fault_off: assert property (o_state == FPM_ST_RUN && (i_fault.oc || i_fault.tr) && !i_fault.ov
        |=> o_state == FPM_ST_FAST && o_drive.fast_off && !o_drive.low_side_on)
        else $error("fast fault not handled");
    a_track_no_pull: assert property (o_state == FPM_ST_RUN && i_fault == 5'h08 && !o_cfg_rdata[5] && !i_cfg_wr
        |=> !o_grp_oe)
        else $error("tracking propagated while disabled");
    a_error_low_side: assert property (o_state == FPM_ST_RUN && i_fault.ov
        |=> o_drive.fast_off && o_drive.low_side_on)
        else $error("error turn-off wrong");
    a_remote_regular: assert property (o_state == FPM_ST_RUN ##0 s_line_low |-> ##[0:6] o_state == FPM_ST_DELAY)
        else $error("remote fault ignored");
    a_remote_fast: assert property (o_state == FPM_ST_RUN ##0 s_err_low |-> ##[0:6] o_state == FPM_ST_FAST)
        else $error("remote error ignored");
    a_hiccup_span: assert property (o_state == FPM_ST_HICCUP ##1 o_state == FPM_ST_RUN
        |-> $past(hic_cnt) >= HICCUP_CYC - 1)
        else $error("hiccup too short");
    a_latch_holds: assert property (o_state == FPM_ST_LATCHED && i_turn_on && !i_status_clear
        |=> o_state == FPM_ST_LATCHED)
        else $error("latched state left");
endmodule : fpm_sva

bind fpm_top fpm_sva #(.HICCUP_CYC(HICCUP_CYC)) u_sva (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_cfg_wr(i_cfg_wr), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_turn_on(i_turn_on),
    .i_fault(i_fault), .i_temp_warn(i_temp_warn), .i_pg_warn(i_pg_warn), .i_status_clear(i_status_clear),
    .i_grp_line(i_grp_line), .i_remote_err(i_remote_err), .o_grp_out(o_grp_out), .o_grp_oe(o_grp_oe),
    .o_drive(o_drive), .o_msg_temp(o_msg_temp), .o_msg_pg(o_msg_pg), .o_state(o_state));

// ==== tb/fpm_partner.sv ====
// Model of the other group members, the power manager and the output.
// Assumes the bench drives its requests just after the clock edge.
module fpm_partner
    import fpm_pkg::*;
#(
    parameter int RAMP_CYC = 4
) (
    input wire logic i_clk,         // Clock
    input wire logic i_arst_n,      // Reset, active low
    input wire logic i_dut_oe,      // Device pulls line
    input wire logic i_pull,        // Another member pulls line
    input wire logic i_err,         // Manager relays an error
    input wire fpm_drive_t i_drive, // Device stage commands
    output logic o_line,            // Resolved group line
    output logic o_relay,           // Line of another group
    output logic o_remote_err,      // Error flag pin
    output logic o_vout_zero        // Output at zero
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ramp_cnt;
    // Pull-up on the shared line; any member pulling wins
    assign o_line = !(i_dut_oe || i_pull);
    assign o_relay = o_line;
    assign o_remote_err = i_err;
    // Output falls over a few cycles so zero is never seen at once
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ramp_cnt <= '0;
            o_vout_zero <= 1'b1;
        end else if (i_drive.ramp_up) begin
            ramp_cnt <= '0;
            o_vout_zero <= 1'b0;
        end else if (i_drive.regular_off || i_drive.fast_off) begin
            ramp_cnt <= ramp_cnt + 8'h01;
            o_vout_zero <= (ramp_cnt >= 8'(RAMP_CYC - 1));
        end
    end
endmodule : fpm_partner

// ==== tb/testbench.sv ====
// Self-checking bench for fpm_top with the group partner model.
// Assumes a shortened hiccup and a turn-off delay of two cycles.
module testbench;
    import fpm_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned HIC = 20;
    logic i_clk, i_arst_n, i_cfg_wr, i_turn_on, i_temp_warn, i_pg_warn, i_status_clear;
    logic i_pull, i_err, grp_line, remote_err, vout_zero, relay, o_grp_out, o_grp_oe, o_msg_temp, o_msg_pg;
    logic [FPM_CFG_W-1:0] i_cfg_wdata, o_cfg_rdata;
    logic [FPM_CNT_W-1:0] i_toff_delay;
    fpm_prot_t i_fault, i_latching, o_fault_status;
    fpm_drive_t o_drive;
    fpm_state_t o_state;
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    fpm_top #(.HICCUP_CYC(HIC)) u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cfg_wr(i_cfg_wr),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_turn_on(i_turn_on), .i_fault(i_fault),
        .i_latching(i_latching), .i_temp_warn(i_temp_warn), .i_pg_warn(i_pg_warn),
        .i_status_clear(i_status_clear), .i_toff_delay(i_toff_delay), .i_vout_zero(vout_zero),
        .i_grp_line(grp_line), .i_remote_err(remote_err), .o_grp_out(o_grp_out), .o_grp_oe(o_grp_oe),
        .o_drive(o_drive), .o_msg_temp(o_msg_temp), .o_msg_pg(o_msg_pg), .o_fault_status(o_fault_status),
        .o_state(o_state));
    fpm_partner u_partner (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_dut_oe(o_grp_oe), .i_pull(i_pull),
        .i_err(i_err), .i_drive(o_drive), .o_line(grp_line), .o_relay(relay), .o_remote_err(remote_err),
        .o_vout_zero(vout_zero));
    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task automatic tick(int k = 1);
        repeat (k) @(posedge i_clk);
        #5;
    endtask : tick
    task automatic chk(logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic chk_st(fpm_state_t exp);
        chk(8'(exp), 8'(o_state));
    endtask : chk_st
    task automatic wait_st(fpm_state_t s, int max);
        int k;
        k = 0;
        while (o_state !== s && k < max) begin
            tick();
            k++;
        end
        chk_st(s);
    endtask : wait_st
    task automatic stay(fpm_state_t s, output int cnt);
        cnt = 0;
        while (o_state === s && cnt < 1000) begin
            tick();
            cnt++;
        end
    endtask : stay
    // A gap cycle keeps the strobe from being set twice in one step
    task automatic cfg(logic [7:0] d);
        i_cfg_wr = 1'b1;
        i_cfg_wdata = d;
        tick();
        i_cfg_wr = 1'b0;
        tick();
    endtask : cfg
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // -------------------------------------------------------------
    // Sequence
    // -------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        #1ms;
        error_cnt++;
        print_verdict();
    end
    initial begin
        {i_arst_n, i_cfg_wr, i_cfg_wdata, i_turn_on, i_fault, i_latching} = '0;
        {i_temp_warn, i_pg_warn, i_status_clear, i_pull, i_err} = '0;
        i_toff_delay = 22'h2;
        tick(20);
        i_arst_n = 1'b1;
        chk(8'h3e, o_cfg_rdata);
        chk(8'h00, 8'({o_grp_oe, o_drive}));
        i_temp_warn = 1'b1;
        i_pg_warn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cfg({i[1:0], 5'h0f, i[0]});
            chk({i[1:0], 5'h0f, i[0]}, o_cfg_rdata);
            chk(8'(i[1:0]), 8'({o_msg_temp, o_msg_pg}));
        end
        i_turn_on = 1'b1;
        wait_st(FPM_ST_RUN, 10);
        // Table: uv, oc, ot, tr, ov; tracking propagation is off
        for (int j = 0; j < 5; j++) begin
            i_fault = fpm_prot_t'(5'h01 << j);
            tick();
            i_fault = '0;
            chk_st((j == 0 || j == 2) ? FPM_ST_DELAY : FPM_ST_FAST);
            chk(8'({j != 3, j == 4}), 8'({o_grp_oe, o_drive.low_side_on}));
            chk(8'(j != 3), 8'(!relay));
            if (j == 0 || j == 2) begin
                stay(FPM_ST_DELAY, n);
                chk(8'h03, 8'(n));
                chk(8'h04, 8'(o_drive));
            end
            wait_st(FPM_ST_HICCUP, 20);
            stay(FPM_ST_HICCUP, n);
            chk(8'(HIC + 1), 8'(n));
            chk_st(FPM_ST_RUN);
            chk(8'h08, 8'({o_grp_oe, o_drive}));
        end
        i_pull = 1'b1;
        wait_st(FPM_ST_DELAY, 8);
        chk(8'h00, 8'(o_grp_oe));
        i_pull = 1'b0;
        wait_st(FPM_ST_RUN, 60);
        i_pull = 1'b1;
        i_err = 1'b1;
        wait_st(FPM_ST_FAST, 8);
        chk(8'h02, 8'(o_drive));
        i_pull = 1'b0;
        i_err = 1'b0;
        wait_st(FPM_ST_RUN, 60);
        i_latching = 5'h02;
        i_fault = 5'h02;
        tick();
        i_fault = '0;
        wait_st(FPM_ST_LATCHED, 60);
        tick(5);
        chk_st(FPM_ST_LATCHED);
        chk(8'h1f, 8'(o_fault_status));
        i_status_clear = 1'b1;
        tick();
        i_status_clear = 1'b0;
        chk(8'h00, 8'(o_fault_status));
        i_latching = '0;
        wait_st(FPM_ST_RUN, 10);
        i_turn_on = 1'b0;
        wait_st(FPM_ST_OFF, 40);
        chk(8'h00, 8'(o_grp_oe));
        print_verdict();
    end
endmodule : testbench
